// *** hw/scpm_pkg.sv ***
`default_nettype none
package scpm_pkg;

  // register addresses on the special function bus
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_SEL = 8'h8F;
  localparam logic [7:0] ADDR_WAKE_MASK = 8'h9F;
  localparam logic [7:0] ADDR_TIMED_UNLOCK = 8'hC9;

  // reset values
  localparam logic [7:0] CLOCK_SEL_RESET = 8'h0C;
  localparam logic [7:0] WAKE_MASK_RESET = 8'hFF;

  // clock selection fields
  localparam int PREDIV_LSB = 4;
  localparam int SETTLE_LSB = 2;
  localparam int SOURCE_LSB = 0;
  localparam logic [1:0] SRC_FAST_A = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_FAST_B = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // power control bit positions
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_STOP_BIT = 1;
  localparam int PWR_SLEEP_BIT = 2;

  // unlock sequence
  localparam logic [7:0] UNLOCK_KEY_1 = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY_2 = 8'h55;
  localparam logic [7:0] UNLOCK_CLOSE = 8'h00;
  localparam logic [8:0] UNLOCK_PERIODS = 9'h100;

  typedef enum logic [2:0] {
    SCPM_RUN = 3'h0,
    SCPM_IDLE = 3'h1,
    SCPM_STOP = 3'h3,
    SCPM_SLEEP = 3'h2,
    SCPM_SETTLE = 3'h6
  } scpm_state_t;

  // fast oscillator pre-divider ratio for a code
  function automatic logic [8:0] scpm_prediv(input logic [3:0] code);
    case (code)
      4'h0: scpm_prediv = 9'h001;
      4'h1: scpm_prediv = 9'h002;
      4'h2: scpm_prediv = 9'h004;
      4'h3: scpm_prediv = 9'h006;
      4'h4: scpm_prediv = 9'h008;
      4'h5: scpm_prediv = 9'h00A;
      4'h6: scpm_prediv = 9'h00C;
      4'h7: scpm_prediv = 9'h00E;
      4'h8: scpm_prediv = 9'h010;
      4'h9: scpm_prediv = 9'h020;
      4'hA: scpm_prediv = 9'h040;
      4'hB: scpm_prediv = 9'h080;
      default: scpm_prediv = 9'h100;
    endcase
  endfunction

  // regulator settle length in slow oscillator cycles
  function automatic logic [8:0] scpm_settle(input logic [1:0] code);
    case (code)
      2'h0: scpm_settle = 9'h004;
      2'h1: scpm_settle = 9'h010;
      2'h2: scpm_settle = 9'h040;
      default: scpm_settle = 9'h100;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** hw/scpm_prediv.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpm_prediv (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fast_osc_on,
  input wire logic [3:0] fast_osc_prediv,
  output logic fast_tick
);

  logic [8:0] cnt;
  logic [8:0] ratio;

  assign ratio = scpm_pkg::scpm_prediv(fast_osc_prediv);

  // counts fast oscillator cycles; a tick marks one divided period
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !fast_osc_on) begin
      cnt <= 9'h000;
    end else if (cnt >= ratio - 9'h001) begin
      cnt <= 9'h000;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_tick <= 1'b0;
    end else begin
      fast_tick <= fast_osc_on && (cnt >= ratio - 9'h001);
    end
  end

endmodule
`default_nettype wire

// *** hw/scpm_top.sv ***
// Summary of operation
// - divider code 0 undivided; codes 1-11 divide 2..128; 12-15 divide 256.
// - settle select picks 4, 16, 64 or 256 slow cycles; resets to 256.
// - source 00/10 divided fast, 01 slow 32k, 11 external; resets fast.
// - clock select writes only while unlock window is open; resets to 0x0C.
// - wake mask resets 0xFF, writable only when unlocked; eight sources.
// - wake from stop or sleep on an edge of an unmasked source.
// - wake detection is independent of interrupt enables.
// - on wake the system clock restarts once the fast oscillator runs.
// - only pins, link wake detector and slow timer can wake stop or sleep.
// - idle gates the cpu clock while peripheral clock keeps running.
// - idle ends on reset or an enabled interrupt request.
// - leaving idle clears the idle bit and resumes the cpu.
// - stop halts all clocks; oscillator disabled one edge after entry.
// - stop ends on reset or unmasked wake edge; bit cleared, settings kept.
// - main regulator stays enabled during stop.
// - sleep disables the main regulator; state is retained.
// - sleep wake enables regulator, waits settle count, restarts clock.
// - unlock window stays open 256 system clock periods, then expires.
// - writing zero to the unlock register closes the window at once.
`timescale 1ns/10ps
`default_nettype none
module scpm_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic slow_osc_32k,
  input wire logic external_clock_in,
  input wire logic [7:0] wake_src,
  input wire logic lin_wake,
  input wire logic slow_wake_timer,
  input wire logic irq_request,
  output logic system_clock_tick,
  output logic cpu_clock_tick,
  output logic fast_osc_en,
  output logic main_reg_en,
  output logic cpu_resume,
  output logic timed_unlock_window
);

  scpm_pkg::scpm_state_t state;
  scpm_pkg::scpm_state_t next_state;
  logic [3:0] fast_osc_prediv;
  logic [1:0] regulator_settle_sel;
  logic [1:0] clock_source_sel;
  logic [7:0] wake_mask;
  logic [2:0] power_control_reg;
  logic unlock_armed;
  logic [8:0] unlock_cnt;
  logic [8:0] settle_cnt;
  logic slow_prev;
  logic ext_prev;
  logic [9:0] wake_prev;
  logic fast_tick;
  logic slow_rise;
  logic ext_rise;
  logic src_tick;
  logic [9:0] wake_level;
  logic wake_event;
  logic wr_unlock;
  logic wr_clock_sel;
  logic wr_wake_mask;
  logic wr_power;
  logic key_open;

  assign wr_unlock = sfr_wr && (sfr_addr == scpm_pkg::ADDR_TIMED_UNLOCK);
  assign wr_clock_sel = sfr_wr && (sfr_addr == scpm_pkg::ADDR_CLOCK_SEL);
  assign wr_wake_mask = sfr_wr && (sfr_addr == scpm_pkg::ADDR_WAKE_MASK);
  assign wr_power = sfr_wr && (sfr_addr == scpm_pkg::ADDR_POWER_CTRL);
  assign key_open = wr_unlock && unlock_armed &&
                    (sfr_wdata == scpm_pkg::UNLOCK_KEY_2);

  scpm_prediv i_scpm_prediv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fast_osc_on(fast_osc_en),
    .fast_osc_prediv(fast_osc_prediv),
    .fast_tick(fast_tick)
  );

  // edge detection of the slow and external clock inputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slow_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      slow_prev <= slow_osc_32k;
      ext_prev <= external_clock_in;
    end
  end

  assign slow_rise = slow_osc_32k && !slow_prev;
  assign ext_rise = external_clock_in && !ext_prev;

  // source multiplexer
  always_comb begin
    case (clock_source_sel)
      scpm_pkg::SRC_SLOW: src_tick = slow_rise;
      scpm_pkg::SRC_EXT: src_tick = ext_rise;
      default: src_tick = fast_tick;
    endcase
  end

  // wake sources: masked interrupt pins plus the unclocked sources
  assign wake_level = {wake_src & wake_mask, lin_wake,
                       slow_wake_timer};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_prev <= 10'h000;
    end else begin
      wake_prev <= wake_level;
    end
  end

  // edge only, regardless of interrupt trigger or enable
  assign wake_event = |(wake_level & ~wake_prev);

  // timed unlock sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unlock_armed <= 1'b0;
    end else if (sfr_wr) begin
      unlock_armed <= wr_unlock &&
                      (sfr_wdata == scpm_pkg::UNLOCK_KEY_1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unlock_cnt <= 9'h000;
    end else if (wr_unlock && sfr_wdata == scpm_pkg::UNLOCK_CLOSE) begin
      unlock_cnt <= 9'h000;
    end else if (key_open) begin
      unlock_cnt <= scpm_pkg::UNLOCK_PERIODS;
    end else if (unlock_cnt != 9'h000 && system_clock_tick) begin
      unlock_cnt <= unlock_cnt - 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timed_unlock_window <= 1'b0;
    end else if (wr_unlock && sfr_wdata == scpm_pkg::UNLOCK_CLOSE) begin
      timed_unlock_window <= 1'b0;
    end else if (key_open) begin
      timed_unlock_window <= 1'b1;
    end else if (unlock_cnt == 9'h001 && system_clock_tick) begin
      timed_unlock_window <= 1'b0;
    end
  end

  // protected clock selection register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_osc_prediv <= scpm_pkg::CLOCK_SEL_RESET[scpm_pkg::PREDIV_LSB +: 4];
      regulator_settle_sel <=
        scpm_pkg::CLOCK_SEL_RESET[scpm_pkg::SETTLE_LSB +: 2];
      clock_source_sel <=
        scpm_pkg::CLOCK_SEL_RESET[scpm_pkg::SOURCE_LSB +: 2];
    end else if (wr_clock_sel && timed_unlock_window) begin
      fast_osc_prediv <= sfr_wdata[scpm_pkg::PREDIV_LSB +: 4];
      regulator_settle_sel <= sfr_wdata[scpm_pkg::SETTLE_LSB +: 2];
      clock_source_sel <= sfr_wdata[scpm_pkg::SOURCE_LSB +: 2];
    end
  end

  // protected wake mask register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_mask <= scpm_pkg::WAKE_MASK_RESET;
    end else if (wr_wake_mask && timed_unlock_window) begin
      wake_mask <= sfr_wdata;
    end
  end

  // register read data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        scpm_pkg::ADDR_CLOCK_SEL:
          sfr_rdata <= {fast_osc_prediv, 2'h0, clock_source_sel};
        scpm_pkg::ADDR_WAKE_MASK: sfr_rdata <= wake_mask;
        scpm_pkg::ADDR_TIMED_UNLOCK:
          sfr_rdata <= {7'h00, timed_unlock_window};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // power mode sequencer
  always_comb begin
    next_state = state;
    case (state)
      scpm_pkg::SCPM_RUN: begin
        if (wr_power && sfr_wdata[scpm_pkg::PWR_SLEEP_BIT]) begin
          next_state = scpm_pkg::SCPM_SLEEP;
        end else if (wr_power && sfr_wdata[scpm_pkg::PWR_STOP_BIT]) begin
          next_state = scpm_pkg::SCPM_STOP;
        end else if (wr_power && sfr_wdata[scpm_pkg::PWR_IDLE_BIT]) begin
          next_state = scpm_pkg::SCPM_IDLE;
        end
      end
      scpm_pkg::SCPM_IDLE: begin
        if (irq_request) begin
          next_state = scpm_pkg::SCPM_RUN;
        end
      end
      scpm_pkg::SCPM_STOP: begin
        if (wake_event) begin
          next_state = scpm_pkg::SCPM_RUN;
        end
      end
      scpm_pkg::SCPM_SLEEP: begin
        if (wake_event) begin
          next_state = scpm_pkg::SCPM_SETTLE;
        end
      end
      scpm_pkg::SCPM_SETTLE: begin
        if (slow_rise && settle_cnt <= 9'h001) begin
          next_state = scpm_pkg::SCPM_RUN;
        end
      end
      default: next_state = scpm_pkg::SCPM_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= scpm_pkg::SCPM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // mode bits; hardware clears them on exit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_control_reg <= 3'h0;
    end else if (state != scpm_pkg::SCPM_RUN &&
                 next_state == scpm_pkg::SCPM_RUN) begin
      power_control_reg <= 3'h0;
    end else if (state == scpm_pkg::SCPM_RUN && wr_power) begin
      power_control_reg <= sfr_wdata[2:0];
    end
  end

  // regulator settle counter on slow oscillator edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      settle_cnt <= 9'h000;
    end else if (state == scpm_pkg::SCPM_SLEEP) begin
      settle_cnt <= scpm_pkg::scpm_settle(regulator_settle_sel);
    end else if (state == scpm_pkg::SCPM_SETTLE && slow_rise) begin
      settle_cnt <= settle_cnt - 9'h001;
    end
  end

  // oscillator off one edge after stop or sleep entry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_osc_en <= 1'b1;
    end else begin
      fast_osc_en <= state == scpm_pkg::SCPM_RUN ||
                     state == scpm_pkg::SCPM_IDLE;
    end
  end

  // regulator off only in sleep
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_reg_en <= 1'b1;
    end else begin
      main_reg_en <= next_state != scpm_pkg::SCPM_SLEEP;
    end
  end

  // clock gating
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= src_tick && (state == scpm_pkg::SCPM_RUN ||
                           state == scpm_pkg::SCPM_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_clock_tick <= 1'b0;
    end else begin
      cpu_clock_tick <= src_tick && state == scpm_pkg::SCPM_RUN;
    end
  end

  // resume pulse toward the cpu on any return to run
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= state != scpm_pkg::SCPM_RUN &&
                    next_state == scpm_pkg::SCPM_RUN;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  clock_sel_locked_a: assert property (
    wr_clock_sel && !timed_unlock_window |=> $stable(clock_source_sel) &&
      $stable(fast_osc_prediv) && $stable(regulator_settle_sel))
    else $error("clock select changed while locked");
  wake_mask_locked_a: assert property (
    wr_wake_mask && !timed_unlock_window |=> $stable(wake_mask))
    else $error("wake mask changed while locked");
  settle_read_zero_a: assert property (
    sfr_rd && sfr_addr == scpm_pkg::ADDR_CLOCK_SEL |=>
      sfr_rdata[3:2] == 2'h0 && sfr_rdata[1:0] == clock_source_sel)
    else $error("clock select read back wrong");
  unlock_open_a: assert property (
    key_open |=> timed_unlock_window && unlock_cnt == scpm_pkg::UNLOCK_PERIODS)
    else $error("unlock sequence did not open window");
  unlock_close_a: assert property (
    wr_unlock && sfr_wdata == scpm_pkg::UNLOCK_CLOSE |=>
      !timed_unlock_window)
    else $error("zero write did not close window");
  unlock_expire_a: assert property (
    unlock_cnt == 9'h001 && system_clock_tick && !wr_unlock |=>
      !timed_unlock_window)
    else $error("window did not expire");
  stop_osc_off_a: assert property (
    state == scpm_pkg::SCPM_STOP && $past(state) == scpm_pkg::SCPM_STOP
      |-> !fast_osc_en && !system_clock_tick)
    else $error("oscillator still on in stop");
  stop_regulator_a: assert property (
    state == scpm_pkg::SCPM_STOP |-> main_reg_en)
    else $error("regulator off in stop");
  sleep_regulator_a: assert property (
    state == scpm_pkg::SCPM_SLEEP |-> !main_reg_en)
    else $error("regulator on in sleep");
  stop_wake_a: assert property (
    state == scpm_pkg::SCPM_STOP && wake_event |=>
      state == scpm_pkg::SCPM_RUN && power_control_reg == 3'h0 ##1
      fast_osc_en)
    else $error("stop did not end on wake");
  idle_gate_a: assert property (
    state == scpm_pkg::SCPM_IDLE && $past(state) == scpm_pkg::SCPM_IDLE
      |-> !cpu_clock_tick)
    else $error("cpu clock ran in idle");
  idle_exit_a: assert property (
    state == scpm_pkg::SCPM_IDLE && irq_request |=>
      state == scpm_pkg::SCPM_RUN && cpu_resume)
    else $error("idle did not end on interrupt");
  sleep_settle_a: assert property (
    state == scpm_pkg::SCPM_SLEEP && wake_event |=>
      state == scpm_pkg::SCPM_SETTLE ##1 main_reg_en && !system_clock_tick)
    else $error("sleep wake did not settle");
endmodule
`default_nettype wire

// *** sim/scpm_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpm_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic system_clock_tick,
  input wire logic cpu_clock_tick,
  input wire logic cpu_resume
);
  int sys_cnt;
  int cpu_cnt;
  int resume_cnt;
  // peripherals step on system ticks, the core only on cpu ticks
  always @(posedge ref_clk) begin
    if (rst_n !== 1'b1) begin
      sys_cnt <= 0;
      cpu_cnt <= 0;
      resume_cnt <= 0;
    end else begin
      if (system_clock_tick === 1'b1) sys_cnt <= sys_cnt + 1;
      if (cpu_clock_tick === 1'b1) cpu_cnt <= cpu_cnt + 1;
      if (cpu_resume === 1'b1) resume_cnt <= resume_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_scpm_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_scpm_top;
  localparam logic [7:0] A_PC = scpm_pkg::ADDR_POWER_CTRL;
  localparam logic [7:0] A_CS = scpm_pkg::ADDR_CLOCK_SEL;
  localparam logic [7:0] A_WM = scpm_pkg::ADDR_WAKE_MASK;
  localparam logic [7:0] A_UL = scpm_pkg::ADDR_TIMED_UNLOCK;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic slow_osc_32k = 1'b0;
  logic external_clock_in = 1'b0;
  logic [7:0] wake_src = 8'h00;
  logic lin_wake = 1'b0;
  logic slow_wake_timer = 1'b0;
  logic irq_request = 1'b0;
  logic system_clock_tick, cpu_clock_tick, fast_osc_en, main_reg_en;
  logic cpu_resume, timed_unlock_window;
  int bad_count = 0;
  int comparisons = 0;
  int slow_div = 0;
  int ext_div = 0;
  int ratio [16] = '{1, 2, 4, 6, 8, 10, 12, 14, 16, 32, 64, 128, 256, 256,
    256, 256};
  logic [7:0] src_val [3] = '{8'h01, 8'h03, 8'h02};
  int src_ticks [3] = '{10, 16, 160};

  scpm_top i_scpm_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .slow_osc_32k(slow_osc_32k), .external_clock_in(external_clock_in),
    .wake_src(wake_src), .lin_wake(lin_wake),
    .slow_wake_timer(slow_wake_timer), .irq_request(irq_request),
    .system_clock_tick(system_clock_tick), .cpu_clock_tick(cpu_clock_tick),
    .fast_osc_en(fast_osc_en), .main_reg_en(main_reg_en),
    .cpu_resume(cpu_resume), .timed_unlock_window(timed_unlock_window));
  scpm_cpu_model i_scpm_cpu_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .system_clock_tick(system_clock_tick), .cpu_clock_tick(cpu_clock_tick),
    .cpu_resume(cpu_resume));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // slow oscillator period 16 cycles, external clock period 10 cycles
  always @(posedge ref_clk) begin
    #1;
    slow_div = (slow_div + 1) % 8;
    ext_div = (ext_div + 1) % 5;
    if (slow_div == 0) slow_osc_32k = ~slow_osc_32k;
    if (ext_div == 0) external_clock_in = ~external_clock_in;
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    step(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    chk8(sfr_rdata, exp);
  endtask
  task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
    wr(A_UL, scpm_pkg::UNLOCK_KEY_1);
    wr(A_UL, scpm_pkg::UNLOCK_KEY_2);
    wr(a, d);
    wr(A_UL, scpm_pkg::UNLOCK_CLOSE);
  endtask
  task automatic wait_resume(input int lim, input bit must, output int cyc);
    cyc = -1;
    for (int i = 1; i <= lim && cyc < 0; i++) begin
      step(1);
      if (cpu_resume === 1'b1) cyc = i;
    end
    comparisons++;
    if ((cyc >= 0) != must) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cyc >= 0, must);
      if (must) report_and_stop();
    end
  endtask

  task automatic t_reset;
    rd_chk(A_CS, 8'h00);
    rd_chk(A_WM, 8'hFF);
    rd_chk(A_UL, 8'h00);
    rd_chk(A_PC, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk8({7'h00, fast_osc_en}, 8'h01);
    chk8({7'h00, main_reg_en}, 8'h01);
  endtask
  task automatic t_locked;
    wr(A_CS, 8'hF3);
    rd_chk(A_CS, 8'h00);
    wr(A_WM, 8'h00);
    rd_chk(A_WM, 8'hFF);
  endtask
  task automatic t_window;
    wr(A_UL, 8'hAA);
    wr(A_UL, 8'h55);
    rd_chk(A_UL, 8'h01);
    step(240);
    chk8({7'h00, timed_unlock_window}, 8'h01);
    step(20);
    chk8({7'h00, timed_unlock_window}, 8'h00);
    wr(A_UL, 8'hAA);
    wr(A_UL, 8'h55);
    wr(A_UL, 8'h00);
    step(1);
    chk8({7'h00, timed_unlock_window}, 8'h00);
    wr(A_UL, 8'hAA);
    wr(A_WM, 8'h00);
    wr(A_UL, 8'h55);
    chk8({7'h00, timed_unlock_window}, 8'h00);
    rd_chk(A_WM, 8'hFF);
  endtask
  task automatic t_sleep(input int n, input logic [7:0] keep);
    int cyc;
    wr(A_PC, 8'h04);
    step(3);
    chk8({6'h00, main_reg_en, fast_osc_en}, 8'h00);
    slow_wake_timer = 1'b1;
    step(3);
    chk8({7'h00, main_reg_en}, 8'h01);
    wait_resume(n * 16 + 40, 1'b1, cyc);
    chk_near(cyc, (n - 1) * 16 - 3, n * 16 + 16);
    slow_wake_timer = 1'b0;
    rd_chk(A_WM, keep);
  endtask
  task automatic t_prediv;
    int n0;
    for (int c = 0; c < 16; c++) begin
      prot_wr(A_CS, 8'(c << 4));
      rd_chk(A_CS, 8'(c << 4));
      n0 = i_scpm_cpu_model.sys_cnt;
      step(1024);
      n0 = i_scpm_cpu_model.sys_cnt - n0;
      chk_near(n0, 1024 / ratio[c] - 1, 1024 / ratio[c] + 1);
    end
  endtask
  task automatic t_source;
    int n0;
    for (int k = 0; k < 3; k++) begin
      prot_wr(A_CS, src_val[k]);
      rd_chk(A_CS, src_val[k]);
      n0 = i_scpm_cpu_model.sys_cnt;
      step(160);
      n0 = i_scpm_cpu_model.sys_cnt - n0;
      chk_near(n0, src_ticks[k] - 1, src_ticks[k] + 1);
    end
    prot_wr(A_CS, 8'h00);
  endtask
  task automatic t_stop;
    int cyc;
    int n0;
    prot_wr(A_WM, 8'h01);
    rd_chk(A_WM, 8'h01);
    wake_src = 8'h01;
    wr(A_PC, 8'h02);
    step(2);
    chk8({6'h00, main_reg_en, fast_osc_en}, 8'h02);
    n0 = i_scpm_cpu_model.sys_cnt;
    wake_src = 8'h03;
    wait_resume(30, 1'b0, cyc);
    chk_near(i_scpm_cpu_model.sys_cnt - n0, 0, 0);
    wake_src = 8'h02;
    step(2);
    wake_src = 8'h03;
    wait_resume(10, 1'b1, cyc);
    step(2);
    chk8({7'h00, fast_osc_en}, 8'h01);
    rd_chk(A_CS, 8'h00);
    rd_chk(A_PC, 8'h00);
    wake_src = 8'h00;
    wr(A_PC, 8'h02);
    step(5);
    lin_wake = 1'b1;
    wait_resume(10, 1'b1, cyc);
    lin_wake = 1'b0;
  endtask
  task automatic t_idle;
    int cyc;
    int c0;
    int s0;
    wr(A_PC, 8'h01);
    step(2);
    c0 = i_scpm_cpu_model.cpu_cnt;
    s0 = i_scpm_cpu_model.sys_cnt;
    step(50);
    chk_near(i_scpm_cpu_model.cpu_cnt - c0, 0, 0);
    chk_near(i_scpm_cpu_model.sys_cnt - s0, 50, 50);
    wake_src = 8'h01;
    wait_resume(20, 1'b0, cyc);
    irq_request = 1'b1;
    wait_resume(5, 1'b1, cyc);
    irq_request = 1'b0;
    wake_src = 8'h00;
    c0 = i_scpm_cpu_model.cpu_cnt;
    step(10);
    chk_near(i_scpm_cpu_model.cpu_cnt - c0, 9, 10);
  endtask
  task automatic t_idle_reset;
    int c0;
    wr(A_PC, 8'h01);
    step(3);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    c0 = i_scpm_cpu_model.cpu_cnt;
    step(10);
    chk_near(i_scpm_cpu_model.cpu_cnt - c0, 8, 10);
    rd_chk(A_WM, 8'hFF);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_locked();
    t_window();
    t_sleep(256, 8'hFF);
    t_prediv();
    t_source();
    t_stop();
    t_idle();
    t_sleep(4, 8'h01);
    prot_wr(A_CS, 8'h04);
    rd_chk(A_CS, 8'h00);
    t_sleep(16, 8'h01);
    prot_wr(A_CS, 8'h08);
    t_sleep(64, 8'h01);
    chk_near(i_scpm_cpu_model.resume_cnt, 7, 7);
    t_idle_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
